// File: common/ahi_pkg.sv
// constants, opcodes and states of the converter serial host interface
// assumes one device clock (t_clk) and a host-driven serial clock
`default_nettype none
package ahi_pkg;
   localparam int WORD_BITS = 24;
   localparam int FRAME_BITS = 72;
   localparam logic [6:0] FRAME_LAST = 7'h47;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   localparam logic [3:0] STATUS_PREFIX = 4'hc;
   localparam int STATUS_ZERO_BITS = 13;
   // modulator clock period in device clocks
   localparam int MOD_DIV = 4;
   localparam int PD_MOD_CYCLES = 512;
   localparam logic [11:0] PD_LOW_CLKS = 12'(PD_MOD_CYCLES * MOD_DIV);
   localparam logic [4:0] INIT_CLKS = 5'h12;
   // opcodes
   localparam logic [7:0] OP_RESET = 8'h06;
   localparam logic [7:0] OP_START = 8'h08;
   localparam logic [7:0] OP_STOP = 8'h0a;
   localparam logic [2:0] OP_WRITE_PREFIX = 3'h2;
   // register addresses and fields
   localparam logic [4:0] ADDR_MAIN_CFG = 5'h01;
   localparam logic [4:0] ADDR_RESP_A = 5'h09;
   localparam logic [4:0] ADDR_RESP_B = 5'h0a;
   localparam logic [4:0] ADDR_PIN = 5'h0b;
   localparam int SINGLE_SHOT_BIT = 7;
   localparam int PIN_DIR_LSB = 2;
   localparam logic [7:0] MAIN_CFG_RST = 8'h00;
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam logic [1:0] PIN_DIR_RST = 2'h3;
   typedef enum logic [1:0] {
      CMD_OPCODE,
      CMD_COUNT,
      CMD_DATA
   } ahi_cmd_t;
endpackage : ahi_pkg
`default_nettype wire

// File: src/ahi_serial_if.sv
// serial host interface of a two-channel converter: frame output, commands,
// pin control, power-down/reset handling and conversion start gating.
// assumes the converter core delivers samples and a done pulse on CLK_SYS_I.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ahi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : ahi_sync

////////////////////////////////////////////////////////////////////////////////
module ahi_serial_if (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic DIN_I,
   input wire logic START_I,
   input wire logic POWERDOWN_RESET_N_N_I,
   input wire logic [1:0] GPIO_I,
   input wire logic CONV_DONE_I,
   input wire logic [23:0] CH1_DATA_I,
   input wire logic [23:0] CH2_DATA_I,
   input wire logic [4:0] LEAD_OFF_FLAGS_I,
   input wire logic [1:0] CH_POWERDOWN_I,
   output logic DATA_READY_N_O,
   output logic DOUT_O,
   output logic DOUT_OE_O,
   output logic [1:0] GPIO_O,
   output logic [1:0] GPIO_OE_O,
   output logic [1:0] GPIO_LEVEL_O,
   output logic POWERED_DOWN_O,
   output logic FILTER_RESET_O,
   output logic CONV_START_O,
   output logic INIT_BUSY_O,
   output logic [7:0] MAIN_CONFIG_O,
   output logic [7:0] RESP_CFG_A_O,
   output logic [7:0] RESP_CFG_B_O
);

   // shared between domains: hold_r/hold_en_r are quasi-static words that the
   // link side only copies at a frame start; all events cross by toggles
   logic link_rst_r, hold_en_r;
   logic [ahi_pkg::FRAME_BITS-1:0] hold_r;

   ////////////////////////////////////////////////////////////////////////////
   // link domain, rising edges: output shifter
   logic link_rst, tx_last;
   logic [6:0] tx_idx_r;
   logic [ahi_pkg::FRAME_BITS-1:0] tx_shift_r;

   assign link_rst = CS_N_I | link_rst_r;
   assign tx_last = (tx_idx_r == ahi_pkg::FRAME_LAST);

   always_ff @(posedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         tx_idx_r <= 7'h00;
         tx_shift_r <= '0;
         DOUT_O <= 1'b0;
         DOUT_OE_O <= 1'b0;
      end else begin
         if (tx_idx_r == 7'h00) begin
            tx_shift_r <= {hold_r[ahi_pkg::FRAME_BITS-2:0], 1'b0};
            DOUT_O <= hold_r[ahi_pkg::FRAME_BITS-1];
            DOUT_OE_O <= hold_en_r;
         end else begin
            tx_shift_r <= {tx_shift_r[ahi_pkg::FRAME_BITS-2:0], 1'b0};
            DOUT_O <= tx_shift_r[ahi_pkg::FRAME_BITS-1];
         end
         tx_idx_r <= tx_last ? 7'h00 : tx_idx_r + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain, falling edges: input sampling and busy flag
   logic [2:0] rx_cnt_r;
   logic [6:0] rx_shift_r;
   logic busy_r;

   always_ff @(negedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         rx_cnt_r <= 3'h0;
         rx_shift_r <= 7'h00;
         busy_r <= 1'b0;
      end else begin
         rx_cnt_r <= rx_cnt_r + 3'h1;
         rx_shift_r <= {rx_shift_r[5:0], DIN_I};
         // busy covers a frame from its first bit to its last
         busy_r <= (tx_idx_r != 7'h00);
      end
   end

   // these survive chip select so that raising it never fakes an event
   logic [7:0] rx_byte_r;
   logic rx_tog_r;
   logic fall_tog_r;

   always_ff @(negedge SCLK_I or posedge link_rst_r) begin
      if (link_rst_r) begin
         rx_byte_r <= 8'h00;
         rx_tog_r <= 1'b0;
         fall_tog_r <= 1'b0;
      end else begin
         fall_tog_r <= ~fall_tog_r;
         if (!CS_N_I && rx_cnt_r == ahi_pkg::BYTE_LAST) begin
            rx_byte_r <= {rx_shift_r, DIN_I};
            rx_tog_r <= ~rx_tog_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers into the device clock domain
   logic s_busy, s_rx_tog, s_fall_tog, s_start, s_pwdn_n;
   logic [1:0] s_gpio;

   ahi_sync #(
      .W(7),
      .RST_VAL(7'h10)
   ) u_sync (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .d_i({busy_r, rx_tog_r, fall_tog_r, POWERDOWN_RESET_N_N_I, START_I, GPIO_I}),
      .q_o({s_busy, s_rx_tog, s_fall_tog, s_pwdn_n, s_start, s_gpio})
   );

   ////////////////////////////////////////////////////////////////////////////
   // event decode
   logic rx_tog_d_r, fall_tog_d_r, start_d_r, byte_evt, fall_evt, start_rise;
   logic [4:0] init_cnt_r;
   logic init_busy, op_evt, op_reset, op_start, op_stop, wr_en, rst_req;
   ahi_pkg::ahi_cmd_t cmd_state_r, cmd_state_nxt;

   assign byte_evt = s_rx_tog ^ rx_tog_d_r;
   assign fall_evt = s_fall_tog ^ fall_tog_d_r;
   assign start_rise = s_start & ~start_d_r;
   assign init_busy = (init_cnt_r != 5'h00);
   assign op_evt = byte_evt & ~init_busy & (cmd_state_r == ahi_pkg::CMD_OPCODE);
   assign op_reset = op_evt & (rx_byte_r == ahi_pkg::OP_RESET);
   assign op_start = op_evt & (rx_byte_r == ahi_pkg::OP_START);
   assign op_stop = op_evt & (rx_byte_r == ahi_pkg::OP_STOP);
   assign wr_en = byte_evt & ~init_busy & (cmd_state_r == ahi_pkg::CMD_DATA);
   // the pin keeps the device in reset while low, so every fall resets
   assign rst_req = RESET_I | ~s_pwdn_n | op_reset;

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         rx_tog_d_r <= 1'b0;
         fall_tog_d_r <= 1'b0;
         start_d_r <= 1'b0;
         link_rst_r <= 1'b1;
      end else begin
         rx_tog_d_r <= s_rx_tog;
         fall_tog_d_r <= s_fall_tog;
         start_d_r <= s_start;
         link_rst_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset sequencing and power-down
   logic [11:0] pd_cnt_r;

   always_ff @(posedge CLK_SYS_I) begin
      if (rst_req) begin
         init_cnt_r <= ahi_pkg::INIT_CLKS;
      end else if (init_busy) begin
         init_cnt_r <= init_cnt_r - 5'h01;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I || s_pwdn_n) begin
         pd_cnt_r <= 12'h000;
         POWERED_DOWN_O <= 1'b0;
      end else begin
         // reset already applied from the first low cycle; power-down follows
         if (pd_cnt_r != ahi_pkg::PD_LOW_CLKS) begin
            pd_cnt_r <= pd_cnt_r + 12'h001;
         end
         POWERED_DOWN_O <= (pd_cnt_r == ahi_pkg::PD_LOW_CLKS);
      end
   end

   assign INIT_BUSY_O = init_busy;

   ////////////////////////////////////////////////////////////////////////////
   // command parser: write command, byte count, then data bytes
   logic [4:0] wr_addr_r, wr_left_r;

   always_comb begin
      cmd_state_nxt = cmd_state_r;
      if (byte_evt && !init_busy) begin
         case (cmd_state_r)
            ahi_pkg::CMD_OPCODE: begin
               if (rx_byte_r[7:5] == ahi_pkg::OP_WRITE_PREFIX) begin
                  cmd_state_nxt = ahi_pkg::CMD_COUNT;
               end
            end
            ahi_pkg::CMD_COUNT: begin
               cmd_state_nxt = ahi_pkg::CMD_DATA;
            end
            ahi_pkg::CMD_DATA: begin
               if (wr_left_r == 5'h00) begin
                  cmd_state_nxt = ahi_pkg::CMD_OPCODE;
               end
            end
            default: begin
               cmd_state_nxt = ahi_pkg::CMD_OPCODE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (rst_req || init_busy) begin
         cmd_state_r <= ahi_pkg::CMD_OPCODE;
         wr_addr_r <= 5'h00;
         wr_left_r <= 5'h00;
      end else begin
         cmd_state_r <= cmd_state_nxt;
         if (op_evt) begin
            wr_addr_r <= rx_byte_r[4:0];
         end else if (wr_en) begin
            wr_addr_r <= wr_addr_r + 5'h01;
         end
         if (byte_evt && cmd_state_r == ahi_pkg::CMD_COUNT) begin
            wr_left_r <= rx_byte_r[4:0];
         end else if (wr_en) begin
            wr_left_r <= wr_left_r - 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers and general-purpose pins
   logic wr_main, wr_resp_a, wr_resp_b, wr_pin;
   logic [1:0] pin_direction_bits_r, dir_nxt, level_nxt;

   assign wr_main = wr_en & (wr_addr_r == ahi_pkg::ADDR_MAIN_CFG);
   assign wr_resp_a = wr_en & (wr_addr_r == ahi_pkg::ADDR_RESP_A);
   assign wr_resp_b = wr_en & (wr_addr_r == ahi_pkg::ADDR_RESP_B);
   assign wr_pin = wr_en & (wr_addr_r == ahi_pkg::ADDR_PIN);
   assign dir_nxt = wr_pin ? rx_byte_r[ahi_pkg::PIN_DIR_LSB +: 2] : pin_direction_bits_r;
   // a set direction bit means input; inputs keep their old output level
   assign level_nxt = wr_pin ? ((rx_byte_r[1:0] & ~dir_nxt) | (GPIO_O & dir_nxt)) : GPIO_O;

   always_ff @(posedge CLK_SYS_I) begin
      if (init_busy) begin
         MAIN_CONFIG_O <= ahi_pkg::MAIN_CFG_RST;
         RESP_CFG_A_O <= ahi_pkg::RESP_RST;
         RESP_CFG_B_O <= ahi_pkg::RESP_RST;
         pin_direction_bits_r <= ahi_pkg::PIN_DIR_RST;
         GPIO_OE_O <= ~ahi_pkg::PIN_DIR_RST;
         GPIO_O <= 2'h0;
         FILTER_RESET_O <= 1'b0;
      end else begin
         if (wr_main) begin
            MAIN_CONFIG_O <= rx_byte_r;
         end
         if (wr_resp_a) begin
            RESP_CFG_A_O <= rx_byte_r;
         end
         if (wr_resp_b) begin
            RESP_CFG_B_O <= rx_byte_r;
         end
         pin_direction_bits_r <= dir_nxt;
         GPIO_OE_O <= ~dir_nxt;
         GPIO_O <= level_nxt;
         FILTER_RESET_O <= wr_main | wr_resp_a | wr_resp_b;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         GPIO_LEVEL_O <= 2'h0;
      end else begin
         GPIO_LEVEL_O <= s_gpio;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion control and frame publication
   logic opcode_run_r, one_shot_done_r, started_r, conv_run, start_evt, accept_done, pend_valid_r, hold_load;
   logic [ahi_pkg::FRAME_BITS-1:0] pend_frame_r, new_frame;
   logic [ahi_pkg::WORD_BITS-1:0] ch1_word, ch2_word;

   assign start_evt = ~init_busy & (start_rise | op_start);
   assign conv_run = s_start | opcode_run_r;
   assign accept_done = CONV_DONE_I & conv_run & ~one_shot_done_r & ~init_busy;
   assign ch1_word = CH_POWERDOWN_I[0] ? '0 : CH1_DATA_I;
   assign ch2_word = CH_POWERDOWN_I[1] ? '0 : CH2_DATA_I;
   assign new_frame = {ahi_pkg::STATUS_PREFIX, LEAD_OFF_FLAGS_I, s_gpio,
                       {ahi_pkg::STATUS_ZERO_BITS{1'b0}}, ch1_word, ch2_word};
   // never change the published word while a frame is being shifted
   assign hold_load = pend_valid_r & ~s_busy;

   always_ff @(posedge CLK_SYS_I) begin
      if (init_busy) begin
         opcode_run_r <= 1'b0;
         one_shot_done_r <= 1'b0;
         CONV_START_O <= 1'b0;
      end else begin
         if (op_start) begin
            opcode_run_r <= 1'b1;
         end else if (op_stop) begin
            opcode_run_r <= 1'b0;
         end
         // an accepted result in the same cycle as a start still uses up the shot
         if (accept_done && MAIN_CONFIG_O[ahi_pkg::SINGLE_SHOT_BIT]) begin
            one_shot_done_r <= 1'b1;
         end else if (start_evt) begin
            one_shot_done_r <= 1'b0;
         end
         CONV_START_O <= start_evt;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         started_r <= 1'b0;
         hold_en_r <= 1'b0;
      end else begin
         if (start_rise) begin
            started_r <= 1'b1;
         end
         hold_en_r <= started_r;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (init_busy) begin
         pend_valid_r <= 1'b0;
         pend_frame_r <= '0;
         hold_r <= '0;
         DATA_READY_N_O <= 1'b1;
      end else begin
         pend_valid_r <= accept_done | (pend_valid_r & s_busy);
         if (accept_done) begin
            pend_frame_r <= new_frame;
         end
         // a new result wins over a falling serial clock edge in the same cycle
         if (hold_load) begin
            hold_r <= pend_frame_r;
            DATA_READY_N_O <= 1'b0;
         end else if (fall_evt || start_evt) begin
            DATA_READY_N_O <= 1'b1;
         end
      end
   end

endmodule : ahi_serial_if
`default_nettype wire

// File: tb/ahi_serial_if_properties.sv
// concurrent checks on the ports of ahi_serial_if
// assumes the link pins are slow enough to be sampled on the device clock
`default_nettype none
////////////////////////////////////////////////////////////
module ahi_serial_if_props (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic START_I,
   input wire logic POWERDOWN_RESET_N_N_I,
   input wire logic [1:0] GPIO_I,
   input wire logic CONV_DONE_I,
   input wire logic DATA_READY_N_O,
   input wire logic DOUT_OE_O,
   input wire logic [1:0] GPIO_OE_O,
   input wire logic [1:0] GPIO_LEVEL_O,
   input wire logic POWERED_DOWN_O,
   input wire logic FILTER_RESET_O,
   input wire logic CONV_START_O,
   input wire logic INIT_BUSY_O,
   input wire logic [7:0] MAIN_CONFIG_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RESET_I);
   logic done_seen_r;
   logic started_r;
   logic [11:0] low_cnt_r;
   // the low counter saturates so a long power-down never wraps to zero
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         done_seen_r <= 1'b0;
         started_r <= 1'b0;
      end else begin
         done_seen_r <= CONV_DONE_I | (done_seen_r & DATA_READY_N_O);
         started_r <= started_r | (START_I & ~$past(START_I));
      end
      low_cnt_r <= POWERDOWN_RESET_N_N_I ? 12'h000 : low_cnt_r + {11'h000, low_cnt_r != 12'hfff};
   end
   a_oe_off_deselected: assert property (
      CS_N_I && $past(CS_N_I) |-> !DOUT_OE_O) else $error("output driven while deselected");
   a_ready_needs_done: assert property (
      $fell(DATA_READY_N_O) |-> done_seen_r) else $error("ready fell without a result");
   a_no_data_prestart: assert property (
      $rose(DOUT_OE_O) |-> started_r) else $error("output before start rose");
   a_ready_rise_sclk: assert property (
      $fell(SCLK_I) && !INIT_BUSY_O && !CONV_DONE_I |-> ##[2:6] DATA_READY_N_O)
      else $error("ready not raised by serial clock");
   a_pd_not_early: assert property (
      $rose(POWERED_DOWN_O) |-> low_cnt_r >= ahi_pkg::PD_LOW_CLKS) else $error("power-down too early");
   a_pd_on_time: assert property (
      low_cnt_r == ahi_pkg::PD_LOW_CLKS + 12'h008 |-> POWERED_DOWN_O) else $error("power-down missing");
   a_pin_fall_reset: assert property (
      $fell(POWERDOWN_RESET_N_N_I) |-> ##[1:5] INIT_BUSY_O) else $error("pin fall gave no reset");
   a_init_length: assert property (
      $fell(RESET_I) |-> ##16 INIT_BUSY_O ##[1:4] !INIT_BUSY_O) else $error("init length wrong");
   a_pins_input_init: assert property (
      INIT_BUSY_O && $past(INIT_BUSY_O, 2) |-> GPIO_OE_O == 2'h0) else $error("pin driven during init");
   a_level_follows_pin: assert property (
      $stable(GPIO_I) [*5] |-> GPIO_LEVEL_O == GPIO_I) else $error("pin readback wrong");
   a_filter_on_write: assert property (
      $changed(MAIN_CONFIG_O) && MAIN_CONFIG_O != 8'h00 |->
      (FILTER_RESET_O || $past(FILTER_RESET_O) || $past(FILTER_RESET_O, 2)) or (##[1:2] FILTER_RESET_O))
      else $error("no filter reset on write");
   c_ready: cover property ($fell(DATA_READY_N_O));
   c_powerdown: cover property ($rose(POWERED_DOWN_O));
   c_filter: cover property (FILTER_RESET_O);
   c_start: cover property (CONV_START_O);
endmodule : ahi_serial_if_props

bind ahi_serial_if ahi_serial_if_props ahi_serial_if_props_i (
   .CLK_SYS_I, .RESET_I, .SCLK_I, .CS_N_I, .START_I, .POWERDOWN_RESET_N_N_I, .GPIO_I, .CONV_DONE_I,
   .DATA_READY_N_O, .DOUT_OE_O, .GPIO_OE_O, .GPIO_LEVEL_O, .POWERED_DOWN_O, .FILTER_RESET_O,
   .CONV_START_O, .INIT_BUSY_O, .MAIN_CONFIG_O
);
`default_nettype wire

// File: tb/ahi_host_model.sv
// serial master standing in for the host controller
// assumes mode 1: clock idles low, data in sampled by the device on the falling edge
// data in changes on the rising edge so it never races the sampling edge
`default_nettype none
////////////////////////////////////////////////////////////
module ahi_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i,
   input wire logic dout_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // 80 ns serial clock, only running inside a transfer
   task automatic xfer(input int n, input logic [79:0] tx, output logic [79:0] rx, output logic oe);
      rx = '0;
      oe = 1'b0;
      cs_n_o = 1'b0;
      #52.7;
      for (int i = n - 1; i >= 0; i--) begin
         #40 sclk_o = 1'b1;
         din_o = tx[i];
         #40 rx = {rx[78:0], dout_i};
         oe = oe | dout_oe_i;
         sclk_o = 1'b0;
      end
      #25 cs_n_o = 1'b1;
      din_o = 1'b0;
      #60;
   endtask : xfer
endmodule : ahi_host_model
`default_nettype wire

// File: tb/ahi_serial_if_tb.sv
// self-checking bench for ahi_serial_if with a serial host model
// assumes the checker is bound in and the host model drives the link pins
`default_nettype none
////////////////////////////////////////////////////////////
module ahi_serial_if_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst, start, pwdn_n, done, oe, data_ready_n_n, dout, dout_oe, pd, fr, cst, busy;
   logic [23:0] ch1, ch2;
   logic [4:0] flags;
   logic [1:0] ch_pd, ext_pin, gpio_o, gpio_oe, gpio_lvl;
   logic [7:0] main_cfg, resp_a, resp_b;
   logic [79:0] rx;
   logic [71:0] exp_frame;
   wire sclk, cs_n, din, dout_w;
   wire [1:0] pin_w;
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   int fr_cnt = 0;
   int cst_cnt = 0;
   always #2.5 clk = ~clk;
   // undriven output shows the inverse of its last level, never a lucky match
   assign dout_w = dout_oe ? dout : ~dout;
   assign pin_w = (gpio_oe & gpio_o) | (~gpio_oe & ext_pin);
   ahi_serial_if ahi_serial_if_i (
      .CLK_SYS_I(clk), .RESET_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .START_I(start),
      .POWERDOWN_RESET_N_N_I(pwdn_n), .GPIO_I(pin_w), .CONV_DONE_I(done), .CH1_DATA_I(ch1), .CH2_DATA_I(ch2),
      .LEAD_OFF_FLAGS_I(flags), .CH_POWERDOWN_I(ch_pd), .DATA_READY_N_O(data_ready_n_n), .DOUT_O(dout),
      .DOUT_OE_O(dout_oe), .GPIO_O(gpio_o), .GPIO_OE_O(gpio_oe), .GPIO_LEVEL_O(gpio_lvl),
      .POWERED_DOWN_O(pd), .FILTER_RESET_O(fr), .CONV_START_O(cst), .INIT_BUSY_O(busy),
      .MAIN_CONFIG_O(main_cfg), .RESP_CFG_A_O(resp_a), .RESP_CFG_B_O(resp_b)
   );
   ahi_host_model ahi_host_model_i (
      .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w), .dout_oe_i(dout_oe)
   );
   ////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check
   // bounded wait on ready (sel high) or on the init flag
   task automatic wait_for(input logic sel, input logic v);
      int n;
      n = 0;
      while (((sel ? data_ready_n_n : busy) !== v) && n < 60) begin
         tick(1);
         n++;
      end
      check(n < 60, "wait expired");
   endtask : wait_for
   task automatic xfer(input int n, input logic [79:0] tx);
      ahi_host_model_i.xfer(n, tx, rx, oe);
      tick(1);
   endtask : xfer
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      xfer(24, {56'h0, ahi_pkg::OP_WRITE_PREFIX, a, 8'h00, d});
   endtask : wr
   task automatic conv;
      done = 1'b1;
      tick(1);
      done = 1'b0;
   endtask : conv
   always @(posedge clk) begin
      cyc++;
      if (fr === 1'b1) fr_cnt++;
      if (cst === 1'b1) cst_cnt++;
      if (cyc == 30000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         give_verdict;
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      start = 1'b0;
      pwdn_n = 1'b1;
      done = 1'b0;
      ch1 = 24'h800001;
      ch2 = 24'h123456;
      flags = 5'h15;
      ch_pd = 2'h2;
      ext_pin = 2'h2;
      tick(8);
      rst = 1'b0;
      check(gpio_oe === 2'h0 && dout_oe === 1'b0 && data_ready_n_n === 1'b1, "reset outputs");
      tick(14);
      check(busy === 1'b1, "init too short");
      tick(8);
      check(busy === 1'b0, "init too long");
      xfer(72, '0);
      check(oe === 1'b0, "data before start");
      conv;
      tick(8);
      check(data_ready_n_n === 1'b1, "ready while halted");
      start = 1'b1;
      tick(6);
      check(cst_cnt === 1, "no start pulse");
      conv;
      wait_for(1'b1, 1'b0);
      exp_frame = {4'hc, flags, ext_pin, 13'h0, ch1, 24'h0};
      xfer(80, '0);
      check(rx[79:8] === exp_frame && rx[7:0] === exp_frame[71:64], "frame");
      check(oe === 1'b1 && data_ready_n_n === 1'b1, "frame control");
      fork
         xfer(72, '0);
         begin
            tick(200);
            ch1 = 24'h000abc;
            conv;
         end
      join
      check(rx[71:0] === exp_frame, "overlap corrupted");
      wait_for(1'b1, 1'b0);
      xfer(72, '0);
      check(rx[71:0] === {4'hc, flags, ext_pin, 13'h0, 24'h000abc, 24'h0}, "next frame");
      xfer(32, {48'h0, ahi_pkg::OP_WRITE_PREFIX, ahi_pkg::ADDR_RESP_A, 8'h01, 8'h5a, 8'ha5});
      wr(ahi_pkg::ADDR_MAIN_CFG, 8'h80);
      check({main_cfg, resp_a, resp_b} === 24'h805aa5 && fr_cnt === 3, "config write");
      start = 1'b0;
      tick(4);
      xfer(8, {72'h0, ahi_pkg::OP_START});
      check(cst_cnt === 2, "start opcode");
      conv;
      wait_for(1'b1, 1'b0);
      xfer(8, '0);
      conv;
      tick(10);
      check(data_ready_n_n === 1'b1, "second single shot");
      wr(ahi_pkg::ADDR_PIN, 8'h0f);
      check(gpio_oe === 2'h0 && gpio_o === 2'h0, "input pins driven");
      wr(ahi_pkg::ADDR_PIN, 8'h01);
      tick(6);
      check(gpio_oe === 2'h3 && gpio_o === 2'h1 && gpio_lvl === 2'h1, "pin drive");
      xfer(8, {72'h0, ahi_pkg::OP_RESET});
      wait_for(1'b0, 1'b0);
      check(main_cfg === 8'h00 && gpio_oe === 2'h0, "reset opcode");
      wr(ahi_pkg::ADDR_PIN, 8'h01);
      wr(ahi_pkg::ADDR_MAIN_CFG, 8'h80);
      pwdn_n = 1'b0;
      tick(300);
      check(busy === 1'b1 && pd === 1'b0 && gpio_oe === 2'h0, "pin reset");
      tick(1740);
      check(pd === 1'b0, "early power-down");
      tick(20);
      check(pd === 1'b1, "no power-down");
      pwdn_n = 1'b1;
      wait_for(1'b0, 1'b0);
      check(main_cfg === 8'h00, "registers kept");
      give_verdict;
   end
endmodule : ahi_serial_if_tb
`default_nettype wire
